/* File: include/ccd_seq_pkg.sv */
`default_nettype none
package ccd_seq_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned MAX_PIX_HZ      = 6_000_000;
    // half period of the phase clocks, rounded up so the pixel rate stays at or below max
    localparam int unsigned MIN_HALF_CYC    = (CLK_HZ + 2 * MAX_PIX_HZ - 1) / (2 * MAX_PIX_HZ);
    localparam int unsigned CELLS_PER_LINE  = 8022;
    localparam int unsigned PHASES_PER_CELL = 2;
    localparam int unsigned PIX_W           = 14;
    localparam int unsigned DWELL_W         = 8;
    localparam int unsigned HALF_W          = 8;
    localparam logic [PIX_W-1:0]   LAST_CELL    = PIX_W'(CELLS_PER_LINE - 1);
    localparam logic [HALF_W-1:0]  HALF_MIN     = HALF_W'(MIN_HALF_CYC);
    localparam logic [DWELL_W-1:0] DWELL_ONE    = 8'h01;
    localparam logic [HALF_W-1:0]  HALF_ONE     = 8'h01;
    localparam logic [PIX_W-1:0]   PIX_ZERO     = 14'h0000;
    localparam logic [PIX_W-1:0]   PIX_ONE      = 14'h0001;
    localparam logic [DWELL_W-1:0] DWELL_ZERO   = 8'h00;
    localparam logic [HALF_W-1:0]  HALF_ZERO    = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PARK,
        ST_GATES_ON,
        ST_FIRST_OFF,
        ST_SECOND_OFF,
        ST_READ
    } seq_state_t;
endpackage : ccd_seq_pkg
`default_nettype wire

/* File: hw/ccd_clock_sequencer.sv */
// Notes on behaviour
// RULE_01: both transfer gates off while integrating
// RULE_02: park phase one high, two low first
// RULE_03: then turn both transfer gates on
// RULE_04: first gate off moves charge into wells
// RULE_05: second gate off after first gate off
// RULE_06: restart phase clocking after transfer completes
// RULE_07: phases always driven as exact complements
// RULE_08: one phase pair drives all three channels
// RULE_09: device outputs pixel on phase two fall
// RULE_10: pulse reset gate before each pixel
// RULE_11: subtract averaged dark level downstream
// RULE_12: mode select normal or extended range
// RULE_13: count 8022 cells, two transfers each
// RULE_14: phase rate limited to 6 MHz pixels
// RULE_15: configurable dwell; line starts after transfer
`timescale 1ns/1ps
`default_nettype none
module ccd_clock_sequencer
(
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          line_start,
    input  wire logic                          run_enable,
    input  wire logic [ccd_seq_pkg::DWELL_W-1:0] dwell_cycles,
    input  wire logic [ccd_seq_pkg::HALF_W-1:0]  half_cycles,
    input  wire logic                          extended_range_req,
    output logic                               first_transfer_gate,
    output logic                               second_transfer_gate,
    output logic                               phase_one,
    output logic                               phase_two,
    output logic                               reset_gate_drive,
    output logic                               extended_range_mode,
    output logic                               pixel_strobe,
    output logic [ccd_seq_pkg::PIX_W-1:0]      pixel_index,
    output logic                               line_busy,
    output logic                               line_done
);
    import ccd_seq_pkg::*;

    function automatic logic [HALF_W-1:0] clamp_half(input logic [HALF_W-1:0] h);
        clamp_half = (h < HALF_MIN) ? HALF_MIN : h; // RULE_14
    endfunction : clamp_half

    function automatic logic [DWELL_W-1:0] clamp_dwell(input logic [DWELL_W-1:0] d);
        clamp_dwell = (d == DWELL_ZERO) ? DWELL_ONE : d;
    endfunction : clamp_dwell

    function automatic logic dwell_expired(input logic [DWELL_W-1:0] d);
        dwell_expired = (d == DWELL_ONE); // RULE_15
    endfunction : dwell_expired

    function automatic logic [DWELL_W-1:0] dwell_step(input logic [DWELL_W-1:0] d);
        dwell_step = d - DWELL_ONE; // RULE_15
    endfunction : dwell_step

    function automatic logic half_expired(input logic [HALF_W-1:0] h);
        half_expired = (h == HALF_ONE);
    endfunction : half_expired

    function automatic logic [HALF_W-1:0] half_step(input logic [HALF_W-1:0] h);
        half_step = h - HALF_ONE;
    endfunction : half_step

    function automatic logic last_cell(input logic [PIX_W-1:0] c);
        last_cell = (c == LAST_CELL); // RULE_13
    endfunction : last_cell

    // transfer sequencer group
    seq_state_t         state_reg,       state_next;
    logic [DWELL_W-1:0] dwell_reg,       dwell_next;
    logic               first_gate_reg,  first_gate_next;
    logic               second_gate_reg, second_gate_next;
    logic               mode_reg,        mode_next;
    logic               pend_reg,        pend_next;
    logic               busy_reg,        busy_next;
    // readout group
    logic [HALF_W-1:0]  half_reg,        half_next;
    logic [PIX_W-1:0]   cell_reg,        cell_next;
    logic               ph1_reg,         ph1_next;
    logic               low_start_reg,   low_start_next;
    logic               rst_reg,         rst_next;
    logic               strobe_reg,      strobe_next;
    logic               done_reg,        done_next;
    // hand-over between the groups
    logic               read_start;
    logic               read_finish;

    // decoded from registers only, so the two groups form no loop
    always_comb
    begin
        read_start  = 1'b0;
        read_finish = 1'b0;
        if (state_reg == ST_SECOND_OFF)
        begin
            read_start = dwell_expired(dwell_reg);
        end
        else if (state_reg == ST_READ)
        begin
            read_finish = ~ph1_reg && half_expired(half_reg) && last_cell(cell_reg);
        end
    end

    always_comb
    begin
        state_next       = state_reg;
        dwell_next       = dwell_reg;
        first_gate_next  = first_gate_reg;
        second_gate_next = second_gate_reg;
        mode_next        = mode_reg;
        pend_next        = pend_reg | line_start;
        case (state_reg)
            ST_IDLE:
            begin
                // mode only changes between lines so no pixel sees a swing step
                mode_next        = extended_range_req; // RULE_12
                first_gate_next  = 1'b0; // RULE_01
                second_gate_next = 1'b0; // RULE_01
                if (run_enable && pend_next)
                begin
                    // phase one is already parked high outside readout
                    pend_next  = 1'b0;
                    dwell_next = clamp_dwell(dwell_cycles); // RULE_15
                    state_next = ST_PARK; // RULE_02
                end
            end
            ST_PARK:
            begin
                if (dwell_expired(dwell_reg))
                begin
                    first_gate_next  = 1'b1; // RULE_03
                    second_gate_next = 1'b1; // RULE_03
                    dwell_next       = clamp_dwell(dwell_cycles);
                    state_next       = ST_GATES_ON;
                end
                else
                begin
                    dwell_next = dwell_step(dwell_reg);
                end
            end
            ST_GATES_ON:
            begin
                if (dwell_expired(dwell_reg))
                begin
                    first_gate_next = 1'b0; // RULE_04
                    dwell_next      = clamp_dwell(dwell_cycles);
                    state_next      = ST_FIRST_OFF;
                end
                else
                begin
                    dwell_next = dwell_step(dwell_reg);
                end
            end
            ST_FIRST_OFF:
            begin
                if (dwell_expired(dwell_reg))
                begin
                    second_gate_next = 1'b0; // RULE_05
                    dwell_next       = clamp_dwell(dwell_cycles);
                    state_next       = ST_SECOND_OFF;
                end
                else
                begin
                    dwell_next = dwell_step(dwell_reg);
                end
            end
            ST_SECOND_OFF:
            begin
                if (read_start)
                begin
                    state_next = ST_READ; // RULE_06
                end
                else
                begin
                    dwell_next = dwell_step(dwell_reg);
                end
            end
            ST_READ:
            begin
                if (read_finish)
                begin
                    state_next = ST_IDLE; // RULE_15
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg       <= ST_IDLE;
            dwell_reg       <= DWELL_ZERO;
            first_gate_reg  <= 1'b0;
            second_gate_reg <= 1'b0;
            mode_reg        <= 1'b0;
            pend_reg        <= 1'b0;
            busy_reg        <= 1'b0;
        end
        else
        begin
            state_reg       <= state_next;
            dwell_reg       <= dwell_next;
            first_gate_reg  <= first_gate_next;
            second_gate_reg <= second_gate_next;
            mode_reg        <= mode_next;
            pend_reg        <= pend_next;
            busy_reg        <= busy_next;
        end
    end

    always_comb
    begin
        half_next      = half_reg;
        cell_next      = cell_reg;
        ph1_next       = ph1_reg;
        low_start_next = 1'b0;
        // a flag, not a count compare, so a new half length cannot drop a pulse
        rst_next       = low_start_reg; // RULE_10
        strobe_next    = 1'b0;
        done_next      = 1'b0;
        if (read_start)
        begin
            cell_next      = PIX_ZERO;
            half_next      = clamp_half(half_cycles); // RULE_14
            ph1_next       = 1'b0; // RULE_06
            low_start_next = 1'b1;
        end
        else if (state_reg == ST_READ)
        begin
            if (half_expired(half_reg))
            begin
                half_next = clamp_half(half_cycles); // RULE_14
                ph1_next  = ~ph1_reg; // RULE_07
                if (ph1_reg)
                begin
                    // index moves on only when the next cell begins
                    cell_next      = cell_reg + PIX_ONE; // RULE_13
                    low_start_next = 1'b1;
                end
                else
                begin
                    // phase two falls here: device presents a pixel
                    strobe_next = 1'b1; // RULE_09
                    done_next   = read_finish; // RULE_13
                end
            end
            else
            begin
                half_next = half_step(half_reg);
            end
        end
        else
        begin
            ph1_next = 1'b1; // RULE_02
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            half_reg      <= HALF_ZERO;
            cell_reg      <= PIX_ZERO;
            ph1_reg       <= 1'b1;
            low_start_reg <= 1'b0;
            rst_reg       <= 1'b0;
            strobe_reg    <= 1'b0;
            done_reg      <= 1'b0;
        end
        else
        begin
            half_reg      <= half_next;
            cell_reg      <= cell_next;
            ph1_reg       <= ph1_next;
            low_start_reg <= low_start_next;
            rst_reg       <= rst_next;
            strobe_reg    <= strobe_next;
            done_reg      <= done_next;
        end
    end

    // one register feeds both phases so they can never overlap
    assign phase_one            = ph1_reg; // RULE_08
    assign phase_two            = ~ph1_reg; // RULE_07
    assign first_transfer_gate  = first_gate_reg;
    assign second_transfer_gate = second_gate_reg;
    assign reset_gate_drive     = rst_reg;
    assign extended_range_mode  = mode_reg; // RULE_12

    // dark averaging is left downstream; index lets it pick shielded pixels
    assign pixel_strobe         = strobe_reg; // RULE_11
    assign pixel_index          = cell_reg;
    assign line_busy            = busy_reg;
    assign line_done            = done_reg;
endmodule : ccd_clock_sequencer
`default_nettype wire

/* File: tb/ccd_seq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ccd_seq_checker
    import ccd_seq_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    input wire logic             first_transfer_gate,
    input wire logic             second_transfer_gate,
    input wire logic             phase_one,
    input wire logic             phase_two,
    input wire logic             reset_gate_drive,
    input wire logic             extended_range_mode,
    input wire logic             pixel_strobe,
    input wire logic [PIX_W-1:0] pixel_index,
    input wire logic             line_busy,
    input wire logic             line_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_parked; phase_one && !phase_two; endsequence
    sequence s_gates_shut; !first_transfer_gate && !second_transfer_gate; endsequence
    property p_idle_shut; !line_busy |-> s_gates_shut; endproperty
    a_idle_shut: assert property (p_idle_shut) else $error("gate on while idle");
    property p_park; (first_transfer_gate || second_transfer_gate) |-> s_parked; endproperty
    a_park: assert property (p_park) else $error("gate on while clocking");
    property p_both_on; $rose(first_transfer_gate) |-> second_transfer_gate; endproperty
    a_both_on: assert property (p_both_on) else $error("gates not on together");
    property p_first_off; $fell(first_transfer_gate) |-> second_transfer_gate; endproperty
    a_first_off: assert property (p_first_off) else $error("second gate off early");
    property p_compl; phase_two == !phase_one; endproperty
    a_compl: assert property (p_compl) else $error("phases not complementary");
    property p_strobe; $fell(phase_two) |-> pixel_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("no strobe after fall");
    property p_rst_gate; $fell(phase_one) |=> reset_gate_drive; endproperty
    a_rst_gate: assert property (p_rst_gate) else $error("no reset pulse");
    property p_mode; line_busy && $past(line_busy) |-> $stable(extended_range_mode); endproperty
    a_mode: assert property (p_mode) else $error("mode moved in line");
    property p_done; line_done |-> pixel_index == LAST_CELL && !line_busy; endproperty
    a_done: assert property (p_done) else $error("line ended early");
endmodule : ccd_seq_checker
bind ccd_clock_sequencer ccd_seq_checker i_chk
(
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .first_transfer_gate  (first_transfer_gate),
    .second_transfer_gate (second_transfer_gate),
    .phase_one            (phase_one),
    .phase_two            (phase_two),
    .reset_gate_drive     (reset_gate_drive),
    .extended_range_mode  (extended_range_mode),
    .pixel_strobe         (pixel_strobe),
    .pixel_index          (pixel_index),
    .line_busy            (line_busy),
    .line_done            (line_done)
);
`default_nettype wire

/* File: tb/ccd_device_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccd_device_model
(
    input  wire logic first_transfer_gate,
    input  wire logic second_transfer_gate,
    input  wire logic phase_two,
    output int        pix_count,
    output logic      line_loaded
);
    int chan [3] = '{0, 0, 0};
    initial line_loaded = 1'b0;
    // charge reaches the wells only while the second gate still conducts
    always @(negedge first_transfer_gate)
        if (second_transfer_gate === 1'b1) line_loaded = 1'b1;
    // empty registers give nothing; all channels shift on one edge
    always @(negedge phase_two)
        if (line_loaded) foreach (chan[i]) chan[i]++;
    assign pix_count = (chan[0] == chan[1] && chan[1] == chan[2]) ? chan[0] : -1;
endmodule : ccd_device_model
`default_nettype wire

/* File: tb/trilinear_ccd_clock_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module trilinear_ccd_clock_sequencer_test;
    import ccd_seq_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, line_start = 1'b0, run_enable = 1'b0;
    logic extended_range_req = 1'b0;
    logic [DWELL_W-1:0] dwell_cycles = 8'h00;
    logic [HALF_W-1:0] half_cycles = 8'h01;
    logic first_transfer_gate, second_transfer_gate, phase_one, phase_two, reset_gate_drive;
    logic extended_range_mode, pixel_strobe, line_busy, line_done, line_loaded;
    logic [PIX_W-1:0] pixel_index;
    logic [4:0] mon;
    int bad_count = 0, cmp_count = 0, cyc = 0, strobes = 0, resets = 0, pix_count, n;
    ccd_clock_sequencer i_dut
    (
        .ref_clk              (ref_clk),
        .sys_rst              (sys_rst),
        .line_start           (line_start),
        .run_enable           (run_enable),
        .dwell_cycles         (dwell_cycles),
        .half_cycles          (half_cycles),
        .extended_range_req   (extended_range_req),
        .first_transfer_gate  (first_transfer_gate),
        .second_transfer_gate (second_transfer_gate),
        .phase_one            (phase_one),
        .phase_two            (phase_two),
        .reset_gate_drive     (reset_gate_drive),
        .extended_range_mode  (extended_range_mode),
        .pixel_strobe         (pixel_strobe),
        .pixel_index          (pixel_index),
        .line_busy            (line_busy),
        .line_done            (line_done)
    );
    ccd_device_model i_dev
    (
        .first_transfer_gate  (first_transfer_gate),
        .second_transfer_gate (second_transfer_gate),
        .phase_two            (phase_two),
        .pix_count            (pix_count),
        .line_loaded          (line_loaded)
    );
    assign mon = {line_busy, line_done, phase_one, second_transfer_gate, first_transfer_gate};
    always #20 ref_clk = ~ref_clk;
    function automatic int exp_dwell(input int d);
        return (d == 0) ? 1 : d;
    endfunction : exp_dwell
    function automatic int exp_half(input int h);
        return (h < int'(HALF_MIN)) ? int'(HALF_MIN) : h;
    endfunction : exp_half
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // edges counted until the watched output reaches the level, bounded
    task automatic cnt(input int s, input logic v, input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (mon[s] !== v && k < lim);
    endtask : cnt
    task automatic end_of_test();
        $display("counts: compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (reset_gate_drive === 1'b1) resets++;
        if (pixel_strobe === 1'b1)
        begin
            chk(pixel_index, strobes);
            strobes++;
        end
        if (cyc == 60000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(15));
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk({first_transfer_gate, second_transfer_gate, phase_one, line_busy}, 4'h2);
        $display("test reset levels done");
        dwell_cycles = 8'($urandom % 4);
        extended_range_req = 1'b1;
        run_enable = 1'b1;
        line_start = 1'b1;
        @(negedge ref_clk);
        // line taken at the edge just passed; mode is latched, so the request may drop
        line_start = 1'b0;
        extended_range_req = 1'b0;
        cnt(0, 1'b1, 300, n);
        chk(n, exp_dwell(dwell_cycles));
        chk(line_busy, 1'b1);
        chk(extended_range_mode, 1'b1);
        chk(second_transfer_gate, 1'b1);
        cnt(0, 1'b0, 300, n);
        chk(n, exp_dwell(dwell_cycles));
        cnt(1, 1'b0, 300, n);
        chk(n, exp_dwell(dwell_cycles));
        cnt(2, 1'b0, 300, n);
        chk(n, exp_dwell(dwell_cycles));
        cnt(2, 1'b1, 300, n);
        chk(n, exp_half(half_cycles));
        cnt(3, 1'b1, 60000, n);
        chk(extended_range_mode, 1'b1);
        chk(pix_count, CELLS_PER_LINE);
        chk(line_loaded, 1'b1);
        // the last strobe is only counted at the edge after done rises
        repeat (2) @(negedge ref_clk);
        chk(strobes, CELLS_PER_LINE);
        chk(resets, CELLS_PER_LINE);
        $display("test full line done");
        @(negedge ref_clk);
        run_enable = 1'b0;
        line_start = 1'b1;
        @(negedge ref_clk);
        line_start = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(line_busy, 1'b0);
        chk(extended_range_mode, 1'b0);
        run_enable = 1'b1;
        cnt(4, 1'b1, 10, n);
        chk(line_busy, 1'b1);
        cnt(0, 1'b1, 300, n);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        #1;
        chk({first_transfer_gate, second_transfer_gate, phase_one, line_busy}, 4'h2);
        $display("test pending start and abort done");
        end_of_test();
    end
endmodule : trilinear_ccd_clock_sequencer_test
`default_nettype wire
